// file: pkg/sprite_ctl_pkg.sv
package sprite_ctl_pkg;

    // ****************************************
    // Control word layout
    // ****************************************
    localparam int unsigned CTL_WIDTH = 32;
    localparam int unsigned BIT_ENABLE = 31;
    localparam int unsigned BIT_PIPE_GAMMA = 30;
    localparam int unsigned BIT_RSVD_MBZ = 29;
    localparam int unsigned BIT_YUV_BYPASS = 28;
    localparam int unsigned BIT_RANGE_DIS = 27;
    localparam int unsigned FMT_MSB = 26;
    localparam int unsigned FMT_LSB = 25;
    localparam int unsigned BIT_PIPE_CSC = 24;
    localparam int unsigned BIT_SRC_KEY = 22;

    // Reset value of the whole register
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;

    // ****************************************
    // Source pixel formats
    // ****************************************
    localparam logic [1:0] FMT_YUV422 = 2'h0;
    localparam logic [1:0] FMT_RGB2101010 = 2'h1;
    localparam logic [1:0] FMT_RGB8888 = 2'h2;
    localparam logic [1:0] FMT_FP16 = 2'h3;

    // Component depths, blender input is fixed
    localparam logic [4:0] BLEND_BITS = 5'h0c;
    localparam logic [4:0] BITS_YUV = 5'h08;
    localparam logic [4:0] BITS_RGB10 = 5'h0a;
    localparam logic [4:0] BITS_RGB8 = 5'h08;
    localparam logic [4:0] BITS_FP16 = 5'h10;

    // Deep-buffer enable hold states
    typedef enum logic [0:0] {
        EN_FOLLOW = 1'b0,
        EN_HELD = 1'b1
    } en_state_t;

endpackage : sprite_ctl_pkg

// file: tb/sprite_plane_control_chk.sv
`timescale 1ns/1ps
`default_nettype none

module sprite_plane_control_chk
    import sprite_ctl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // Inputs and outputs watched
    input wire logic [31:0] ctl_rdata_out,
    input wire logic surf_trigger_wr_in,
    input wire logic vblank_start_in,
    input wire logic pipe_enabled_in,
    input wire logic deep_buffer_busy_in,
    input wire logic armed_out,
    input wire logic plane_fetch_en_out,
    input wire logic plane_transparent_out,
    input wire logic range_expand_out,
    input wire logic [1:0] src_format_out,
    input wire logic [4:0] src_comp_bits_out,
    input wire logic [4:0] blend_comp_bits_out
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Trigger then armed, and armed waiting for vblank
    sequence arm_s;
        surf_trigger_wr_in ##1 armed_out;
    endsequence
    sequence wait_s;
        armed_out && pipe_enabled_in && plane_fetch_en_out && !vblank_start_in;
    endsequence

    arm_set_a: assert property (surf_trigger_wr_in |-> arm_s)
        else $error("trigger did not arm");
    arm_wait_a: assert property ((wait_s and !surf_trigger_wr_in) |=> armed_out)
        else $error("update before vblank");
    vbl_load_a: assert property (armed_out && vblank_start_in &&
        !surf_trigger_wr_in |=> !armed_out)
        else $error("vblank did not load");
    fmt_stable_a: assert property (!armed_out |=> $stable(src_format_out))
        else $error("format changed unarmed");
    transp_inv_a: assert property (plane_transparent_out != plane_fetch_en_out)
        else $error("transparent wrong");
    deep_hold_a: assert property (deep_buffer_busy_in &&
        !plane_fetch_en_out |=> !plane_fetch_en_out)
        else $error("enable not held");
    range_rgb_a: assert property (src_format_out != FMT_YUV422 |->
        !range_expand_out)
        else $error("range on rgb");
    comp_bits_a: assert property (src_comp_bits_out ==
        (src_format_out == FMT_FP16 ? BITS_FP16 :
        src_format_out == FMT_RGB2101010 ? BITS_RGB10 : BITS_RGB8))
        else $error("component depth wrong");
    blend_bits_a: assert property (blend_comp_bits_out == BLEND_BITS)
        else $error("blender depth wrong");
    rsvd_zero_a: assert property (ctl_rdata_out[29] == 1'b0)
        else $error("reserved bit set");

endmodule : sprite_plane_control_chk

bind sprite_plane_control sprite_plane_control_chk i_chk (.*);

`default_nettype wire

// file: tb/sprite_plane_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sprite_plane_control_tb
    import sprite_ctl_pkg::*;
;
    // ****************************************
    // Signals and design
    // ****************************************
    logic sys_clk_in, rst_b_in, ctl_wr_in, ctl_rd_in, surf_trigger_wr_in;
    logic vblank_start_in, pipe_enabled_in, deep_buffer_busy_in;
    logic [31:0] ctl_wdata_in, ctl_rdata_out;
    logic armed_out, plane_fetch_en_out, plane_transparent_out;
    logic pipe_gamma_route_out, pipe_csc_route_out, yuv_bypass_out;
    logic range_expand_out, src_key_en_out;
    logic [1:0] src_format_out;
    logic [4:0] src_comp_bits_out, blend_comp_bits_out;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;

    sprite_plane_control i_dut (
        .sys_clk_in, .rst_b_in, .ctl_wr_in, .ctl_wdata_in, .ctl_rd_in,
        .ctl_rdata_out, .surf_trigger_wr_in, .vblank_start_in,
        .pipe_enabled_in, .deep_buffer_busy_in, .armed_out,
        .plane_fetch_en_out, .plane_transparent_out, .pipe_gamma_route_out,
        .pipe_csc_route_out, .yuv_bypass_out, .range_expand_out,
        .src_key_en_out, .src_format_out, .src_comp_bits_out,
        .blend_comp_bits_out
    );

    // Clock and hang guard
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            results;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task results;
        if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask : wt
    task wr(input logic [31:0] d);
        @(posedge sys_clk_in) ctl_wr_in <= 1'b1;
        ctl_wdata_in <= d;
        @(posedge sys_clk_in) ctl_wr_in <= 1'b0;
    endtask : wr
    task rd(input logic [31:0] e);
        @(posedge sys_clk_in) ctl_rd_in <= 1'b1;
        @(posedge sys_clk_in) ctl_rd_in <= 1'b0;
        wt(0);
        chk(ctl_rdata_out, e);
    endtask : rd
    task trig;
        @(posedge sys_clk_in) surf_trigger_wr_in <= 1'b1;
        @(posedge sys_clk_in) surf_trigger_wr_in <= 1'b0;
    endtask : trig

    // ****************************************
    // Scenarios
    // ****************************************
    task t_mask;
        chk({plane_transparent_out, plane_fetch_en_out}, 2'h2); // idle
        rd(CTL_RESET); // reset value
        wr(32'hffff_ffff);
        rd(32'hdf40_0000); // bit dropped
        chk(plane_fetch_en_out, 1'b0); // not armed
    endtask : t_mask
    task t_fmt;
        for (int i = 0; i < 8; i++) begin
            wr({3'h0, i[0], i[2], i[1:0], 25'h0});
            trig;
            wt(2);
            chk(src_format_out, i[1:0]); // format field
            chk(src_comp_bits_out, i[1:0] == 2'h3 ? BITS_FP16 : // depth
                i[1:0] == 2'h1 ? BITS_RGB10 : BITS_RGB8);
            chk(range_expand_out, i[2:0] == 3'h0); // range
            chk(yuv_bypass_out, i[0]); // bypass loaded
        end
    endtask : t_fmt
    task t_vbl;
        @(posedge sys_clk_in) pipe_enabled_in <= 1'b1;
        // converter mode is set outside this plane
        // no destination keying while source keying is on
        wr(32'hc140_0000);
        trig;
        wt(2);
        chk({plane_fetch_en_out, pipe_gamma_route_out,
            pipe_csc_route_out, src_key_en_out, armed_out}, 5'h1e);
        wr(32'h8000_0000);
        trig;
        wt(3);
        chk({armed_out, pipe_gamma_route_out}, 2'h3); // waits
        @(posedge sys_clk_in) vblank_start_in <= 1'b1;
        @(posedge sys_clk_in) vblank_start_in <= 1'b0;
        wt(0);
        chk({armed_out, pipe_gamma_route_out, src_key_en_out}, 3'h0);
    endtask : t_vbl
    task t_deep;
        @(posedge sys_clk_in) pipe_enabled_in <= 1'b0;
        wr(32'h0);
        trig;
        wt(2);
        @(posedge sys_clk_in) deep_buffer_busy_in <= 1'b1;
        wr(32'h8000_0000);
        trig;
        wt(3);
        chk(plane_fetch_en_out, 1'b0); // held
        rd(32'h8000_0000); // written copy
        @(posedge sys_clk_in) deep_buffer_busy_in <= 1'b0;
        wt(2);
        chk(plane_fetch_en_out, 1'b1); // released
    endtask : t_deep

    // Main sequence
    initial begin
        {ctl_wr_in, ctl_rd_in, surf_trigger_wr_in, vblank_start_in} = '0;
        {pipe_enabled_in, deep_buffer_busy_in, rst_b_in} = '0;
        ctl_wdata_in = '0;
        repeat (2) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        wt(0);
        t_mask;
        t_fmt;
        t_vbl;
        t_deep;
        results;
    end

endmodule : sprite_plane_control_tb

`default_nettype wire

// file: verilog/sprite_plane_control.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Control word layout
// ****************************************
// 31     plane enable, drives fetch and transparency
// 30     route through the pipe gamma stage
// 29     reserved, must be zero, reads zero
// 28     YUV bypass, stored and routed only
// 27     range correction disable
// 26:25  source pixel format
// 24     route through the pipe colour converter
// 23     reserved here, reads zero
// 22     source keying enable
// 21:0   lower fields live in another block
//
// Every field resets to zero: plane off, no pipe gamma, range
// correction on, packed YUV, no pipe converter, no keying.
//
// Two copies of the word are kept. The staged copy takes every
// write and is what a read returns. The active copy drives the
// plane and loads from the staged copy only at an update point
// after the surface address trigger has armed it. This keeps a
// multi-register update atomic from the plane's point of view.
//
// Update points, once armed:
//   - start of vertical blank
//   - pipe disabled
//   - sprite not yet enabled on the active copy
//
// A trigger that lands on the update edge re-arms, so the next
// update point loads again; the set of the arm flag wins over
// the clear.
//
// Hazards a user should know:
//   - A write in the update cycle is not part of that update;
//     it waits for the next trigger.
//   - While deep-buffer self refresh is active or exiting, a
//     turn-on of the plane is held back and the other fields
//     still load. The plane starts on the cycle after the busy
//     level is seen low.
//   - A later update that turns the plane off cancels the hold.
//   - Status inputs come from logic on this clock and are not
//     synchronised here.
//   - The pipe gamma and converter routes only select a path;
//     the sprite's own gamma and colour logic are untouched.

module sprite_plane_control
    import sprite_ctl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // Register access
    input wire logic ctl_wr_in,
    input wire logic [31:0] ctl_wdata_in,
    input wire logic ctl_rd_in,
    output logic [31:0] ctl_rdata_out,
    input wire logic surf_trigger_wr_in,
    // Pipe status
    input wire logic vblank_start_in,
    input wire logic pipe_enabled_in,
    input wire logic deep_buffer_busy_in,
    // Plane control outputs
    output logic armed_out,
    output logic plane_fetch_en_out,
    output logic plane_transparent_out,
    output logic pipe_gamma_route_out,
    output logic pipe_csc_route_out,
    output logic yuv_bypass_out,
    output logic range_expand_out,
    output logic src_key_en_out,
    output logic [1:0] src_format_out,
    output logic [4:0] src_comp_bits_out,
    output logic [4:0] blend_comp_bits_out
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [31:0] staged;
        logic armed;
        logic act_enable;
        logic act_gamma;
        logic act_yuv_bypass;
        logic act_range_dis;
        logic [1:0] act_fmt;
        logic act_csc;
        logic act_key;
        en_state_t en_state;
        logic [31:0] rdata;
    } state_t;

    // Writable bits of the staged copy
    localparam logic [31:0] WR_MASK = (32'h1 << BIT_ENABLE)
        | (32'h1 << BIT_PIPE_GAMMA) | (32'h1 << BIT_YUV_BYPASS)
        | (32'h1 << BIT_RANGE_DIS) | (32'h1 << FMT_MSB)
        | (32'h1 << FMT_LSB) | (32'h1 << BIT_PIPE_CSC)
        | (32'h1 << BIT_SRC_KEY);

    state_t st_r;
    state_t st_nxt;
    logic update_now;
    logic new_enable;
    logic src_is_rgb;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        // Hold every field unless a branch below changes it
        // Staged copy: a write lands here at once
        // reserved bit masked
        if (ctl_wr_in) begin
            st_nxt.staged = ctl_wdata_in & WR_MASK;
        end
        update_now = st_r.armed && (vblank_start_in || !pipe_enabled_in
            || !st_r.act_enable);
        new_enable = st_r.staged[BIT_ENABLE];
        // Arm: a trigger in the update cycle keeps the arm set
        if (surf_trigger_wr_in) begin
            st_nxt.armed = 1'b1;
        end else if (update_now) begin
            st_nxt.armed = 1'b0;
        end
        if (update_now) begin
            st_nxt.act_gamma = st_r.staged[BIT_PIPE_GAMMA];
            st_nxt.act_yuv_bypass = st_r.staged[BIT_YUV_BYPASS];
            st_nxt.act_range_dis = st_r.staged[BIT_RANGE_DIS];
            st_nxt.act_fmt = st_r.staged[FMT_MSB:FMT_LSB];
            st_nxt.act_csc = st_r.staged[BIT_PIPE_CSC];
            st_nxt.act_key = st_r.staged[BIT_SRC_KEY];
            if (!new_enable) begin
                st_nxt.act_enable = 1'b0;
                st_nxt.en_state = EN_FOLLOW;
            end else if (deep_buffer_busy_in && !st_r.act_enable) begin
                st_nxt.en_state = EN_HELD;
            end else begin
                st_nxt.act_enable = 1'b1;
                st_nxt.en_state = EN_FOLLOW;
            end
        end else begin
            case (st_r.en_state)
                EN_FOLLOW: begin
                    st_nxt.en_state = EN_FOLLOW;
                end
                EN_HELD: begin
                    // Other fields already loaded; only enable waits
                    // apply after exit
                    if (!deep_buffer_busy_in) begin
                        st_nxt.act_enable = 1'b1;
                        st_nxt.en_state = EN_FOLLOW;
                    end
                end
                default: begin
                    st_nxt.en_state = EN_FOLLOW;
                end
            endcase
        end
        // Readback shows the written copy
        // A read with a write in one cycle returns the old word
        if (ctl_rd_in) begin
            st_nxt.rdata = st_r.staged;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= '{
                staged: CTL_RESET,
                armed: 1'b0,
                act_enable: 1'b0,
                act_gamma: 1'b0,
                act_yuv_bypass: 1'b0,
                act_range_dis: 1'b0,
                act_fmt: FMT_YUV422,
                act_csc: 1'b0,
                act_key: 1'b0,
                en_state: EN_FOLLOW,
                rdata: CTL_RESET
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs from the active copy, plus readback, arm flag and fixed blender depth
    // ****************************************
    // Readback of the staged copy, held until the next read
    assign ctl_rdata_out = st_r.rdata;

    // Arm flag, so the pipe can see a pending update
    assign armed_out = st_r.armed;

    // fetch and transparency
    // Both follow the active enable and are never on together
    assign plane_fetch_en_out = st_r.act_enable;
    assign plane_transparent_out = !st_r.act_enable;

    // plane data only
    // Only the route select leaves here; the sprite's own gamma
    // table is neutralised by loading its ramp, not by this bit
    assign pipe_gamma_route_out = st_r.act_gamma;

    // pipe converter routing
    // Independent of the converter inside the sprite
    assign pipe_csc_route_out = st_r.act_csc;

    // YUV bypass is stored and routed only
    assign yuv_bypass_out = st_r.act_yuv_bypass;

    assign src_key_en_out = st_r.act_key;

    assign src_format_out = st_r.act_fmt;

    // blender depth
    // Packed YUV and RGB formats are widened and FP16 narrowed to this depth before blending
    assign blend_comp_bits_out = BLEND_BITS;

    // ****************************************
    // Format decode
    // ****************************************
    // Source is RGB for every format code except packed YUV
    always_comb begin
        case (st_r.act_fmt)
            FMT_YUV422: begin
                src_is_rgb = 1'b0;
            end
            default: begin
                src_is_rgb = 1'b1;
            end
        endcase
    end

    // Range expansion and component depth per format
    always_comb begin
        range_expand_out = !src_is_rgb && !st_r.act_range_dis;
        case (st_r.act_fmt)
            FMT_YUV422: begin
                src_comp_bits_out = BITS_YUV;
            end
            FMT_RGB2101010: begin
                src_comp_bits_out = BITS_RGB10;
            end
            FMT_RGB8888: begin
                src_comp_bits_out = BITS_RGB8;
            end
            FMT_FP16: begin
                src_comp_bits_out = BITS_FP16;
            end
            default: begin
                src_comp_bits_out = BITS_YUV;
            end
        endcase
    end

endmodule : sprite_plane_control

`default_nettype wire
